// ===== include/fet_mux_pkg.sv
package fet_mux_pkg;
   // ****************************************
   // switch counts
   // ****************************************
   localparam int          CHAN_FETS      = 48;             // channel fets, switched as pairs
   localparam int          CHAN_PAIRS     = CHAN_FETS / 2;
   localparam int          BANK_CHANS     = 12;             // channels in each bank
   localparam int          TREE_PAIRS     = 4;
   localparam int          CMD_W          = 7;
   localparam int          STAT_W         = 8;
   // ****************************************
   // command codes
   // ****************************************
   localparam logic [6:0]  CH_RELAY       = 7'h5a;          // 90 isolation relays
   localparam logic [6:0]  CH_SOURCE      = 7'h5b;          // 91 source tree
   localparam logic [6:0]  CH_SENSE       = 7'h5c;          // 92 sense tree
   localparam logic [6:0]  CH_TWO_WIRE    = 7'h5d;          // 93 two-wire resistance
   localparam logic [6:0]  CH_FOUR_WIRE   = 7'h5e;          // 94 four-wire resistance
   localparam logic [6:0]  SE_LAST_CHAN   = 7'h2f;          // 47 last single-ended channel
   localparam logic [6:0]  DIFF_LAST_CHAN = 7'h17;          // 23 last differential channel
   localparam logic [6:0]  BANK_B_FIRST   = 7'h0c;          // 12 first bank b channel
   // ****************************************
   // tree pair positions
   // ****************************************
   localparam int          TREE_SENSE_A   = 0;
   localparam int          TREE_SENSE_B   = 1;
   localparam int          TREE_SOURCE_A  = 2;
   localparam int          TREE_SOURCE_B  = 3;
   // ****************************************
   // status bits and reset values
   // ****************************************
   localparam int          STAT_RELAY_OPEN = 7;
   localparam int          STAT_NO_CABLE   = 6;
   localparam logic [7:0]  STAT_RESET      = 8'hc0;
   localparam logic [11:0] BANK_RESET      = 12'h000;
   localparam logic [3:0]  TREE_RESET      = 4'h0;
endpackage

// ===== logic/fet_mux_switch_control.sv
// How it works
// - 24 channel pairs in two banks of 12, each bank one common node
// - closing a channel in a bank opens every other channel of that bank
// - four tree pairs: two to the sense bus, two to the source bus
// - tree path goes to backplane bus or ribbon cable per selected path
// - differential: 91 source, 92 sense, 93 two-wire, 94 four-wire trees
// - single-ended: only 91, 92, 93 act on trees, 94 ignored
// - single-ended: tree pair picks one high line of a channel pair
// - pseudo-channel 90 connects or isolates the card from the bus
// - relays stay closed until an open command, an overvoltage or a reset
// - overvoltage detector opens relays without any command
// - ribbon cable path may command the switches like the backplane
// - status bit 7 high after open command, low after close command
// - status bit 6 low while ribbon cable attached, high otherwise
`timescale 1ns/1ps
`default_nettype none
module fet_mux_switch_control (
   input  wire logic                             sys_clk,
   input  wire logic                             rstn,
   input  wire logic                             single_ended,
   input  wire logic                             bp_valid,
   input  wire logic [fet_mux_pkg::CMD_W-1:0]    bp_chan,
   input  wire logic                             bp_close,
   input  wire logic                             rib_strobe,
   input  wire logic [fet_mux_pkg::CMD_W-1:0]    rib_chan,
   input  wire logic                             rib_close,
   input  wire logic                             rib_cable_n,
   input  wire logic                             overvoltage,
   output logic      [fet_mux_pkg::BANK_CHANS-1:0] bank_a_q,
   output logic      [fet_mux_pkg::BANK_CHANS-1:0] bank_b_q,
   output logic      [fet_mux_pkg::TREE_PAIRS-1:0] tree_q,
   output logic                                  path_ribbon_q,
   output logic                                  relay_close_q,
   output logic      [fet_mux_pkg::STAT_W-1:0]   status_q
);
   import fet_mux_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_n;

   // two flops so reset leaves on a clock edge
   // entry stays asynchronous, so the switches open even without a clock
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int SYNC_W = CMD_W + 5;
   // cable detect idles high, so reset must not fake an attached cable
   localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(4'h4);
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic              strobe3_q;

   // ribbon number lines need no handshake: the voltmeter holds them
   // steady for three clocks before the strobe rises and while it is high
   assign pin_raw = {rib_chan, rib_close, rib_strobe, rib_cable_n, overvoltage, single_ended};

   // two flops on every pin, third flop only for the strobe edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q   <= SYNC_IDLE;
         sync2_q   <= SYNC_IDLE;
         strobe3_q <= 1'b0;
      end else begin
         sync1_q   <= pin_raw;
         sync2_q   <= sync1_q;
         strobe3_q <= sync2_q[3];
      end
   end

   // pin levels after the second flop; only the strobe is edge detected
   logic             se_s;
   logic             ovp_s;
   logic             cable_n_s;
   logic             rib_evt;
   logic             rib_close_s;
   logic [CMD_W-1:0] rib_chan_s;

   assign se_s        = sync2_q[0];
   assign ovp_s       = sync2_q[1];
   assign cable_n_s   = sync2_q[2];
   assign rib_evt     = sync2_q[3] & ~strobe3_q;   // rising strobe
   assign rib_close_s = sync2_q[4];
   assign rib_chan_s  = sync2_q[SYNC_W-1:5];

   // ****************************************
   // command selection
   // ****************************************
   logic             pend_q;
   logic             pend_d;
   logic [CMD_W-1:0] pchan_q;
   logic [CMD_W-1:0] pchan_d;
   logic             pclose_q;
   logic             pclose_d;
   logic             go;
   logic             go_close;
   logic             go_rib;
   logic [CMD_W-1:0] go_chan;

   // backplane first; a ribbon command waits while it is busy
   // a second strobe while one waits replaces it, so the voltmeter
   // must space its commands; the latest one is the one applied
   always_comb begin
      pend_d   = pend_q;
      pchan_d  = pchan_q;
      pclose_d = pclose_q;
      if (rib_evt) begin
         pend_d   = 1'b1;
         pchan_d  = rib_chan_s;
         pclose_d = rib_close_s;
      end else if (!bp_valid) begin
         pend_d   = 1'b0;
      end
   end

   // pending ribbon command with its latched number
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q   <= 1'b0;
         pchan_q  <= '0;
         pclose_q <= 1'b0;
      end else begin
         pend_q   <= pend_d;
         pchan_q  <= pchan_d;
         pclose_q <= pclose_d;
      end
   end

   // merged command seen by the decode, at most one per cycle
   assign go       = bp_valid | pend_q;
   assign go_rib   = ~bp_valid & pend_q;
   assign go_chan  = bp_valid ? bp_chan : pchan_q;
   assign go_close = bp_valid ? bp_close : pclose_q;

   // ****************************************
   // channel index decode
   // ****************************************
   logic             in_range;
   logic             bank_sel_b;
   logic [CMD_W-1:0] pair_idx;
   logic [CMD_W-1:0] bank_idx;
   logic             odd_line;

   // single-ended numbers name one high line: two lines per pair
   // pseudo-channels fall outside both ranges, so they never touch a bank
   // bank b holds pairs 12 to 23, rebased to 0 to 11 for the one-hot
   always_comb begin
      in_range = se_s ? (go_chan <= SE_LAST_CHAN) : (go_chan <= DIFF_LAST_CHAN);
      pair_idx = se_s ? {1'b0, go_chan[CMD_W-1:1]} : go_chan;
      odd_line = se_s & go_chan[0];
      bank_sel_b = (pair_idx >= BANK_B_FIRST);
      bank_idx = bank_sel_b ? (pair_idx - BANK_B_FIRST) : pair_idx;
   end

   // ****************************************
   // switch state
   // ****************************************
   logic [BANK_CHANS-1:0] bank_a_d;
   logic [BANK_CHANS-1:0] bank_b_d;
   logic [BANK_CHANS-1:0] hot;
   logic [TREE_PAIRS-1:0] tree_d;
   // parity of the last single-ended number picks the a or b tree pair
   logic                  odd_q;
   logic                  odd_d;
   logic                  path_d;
   logic                  relay_d;
   logic [STAT_W-1:0]     status_d;

   // one-hot line for the addressed channel within its bank
   genvar gi;
   generate
      for (gi = 0; gi < BANK_CHANS; gi++) begin : g_hot
         assign hot[gi] = (bank_idx == CMD_W'(gi));
      end
   endgenerate

   // next state of banks, trees, relays and status
   always_comb begin
      bank_a_d = bank_a_q;
      bank_b_d = bank_b_q;
      tree_d   = tree_q;
      odd_d    = odd_q;
      path_d   = path_ribbon_q;
      relay_d  = relay_close_q;
      if (go) begin
         // the route follows whichever side sent the last command
         path_d = go_rib;
         if (in_range) begin
            odd_d = odd_line;
            // a close replaces the bank, so only one channel stays on
            if (bank_sel_b) begin
               bank_b_d = go_close ? hot : (bank_b_q & ~hot);
            end else begin
               bank_a_d = go_close ? hot : (bank_a_q & ~hot);
            end
         end
         // apart from 94 on a single-ended card, which is ignored, any tree close replaces the whole tree state and an open drops
         // every pair, so no stale pair stays on behind a new selection
         case (go_chan)
            CH_RELAY: begin
               relay_d = go_close;
            end
            CH_SOURCE: begin
               if (!go_close) begin
                  tree_d = TREE_RESET;
               end else if (se_s) begin
                  tree_d = TREE_RESET;
                  tree_d[odd_q ? TREE_SOURCE_B : TREE_SOURCE_A] = 1'b1;
               end else begin
                  tree_d = TREE_RESET;
                  tree_d[TREE_SOURCE_A] = 1'b1;
                  tree_d[TREE_SOURCE_B] = 1'b1;
               end
            end
            CH_SENSE: begin
               if (!go_close) begin
                  tree_d = TREE_RESET;
               end else if (se_s) begin
                  tree_d = TREE_RESET;
                  tree_d[odd_q ? TREE_SENSE_B : TREE_SENSE_A] = 1'b1;
               end else begin
                  tree_d = TREE_RESET;
                  tree_d[TREE_SENSE_A] = 1'b1;
                  tree_d[TREE_SENSE_B] = 1'b1;
               end
            end
            // single-ended two-wire closes the sense and source pair of the same side, differential closes all four pairs
            CH_TWO_WIRE: begin
               if (!go_close) begin
                  tree_d = TREE_RESET;
               end else if (se_s) begin
                  tree_d = TREE_RESET;
                  tree_d[odd_q ? TREE_SENSE_B : TREE_SENSE_A] = 1'b1;
                  tree_d[odd_q ? TREE_SOURCE_B : TREE_SOURCE_A] = 1'b1;
               end else begin
                  tree_d = '1;
               end
            end
            // single-ended cards have no four-wire setup, so 94 is ignored
            CH_FOUR_WIRE: begin
               if (!se_s) begin
                  tree_d = TREE_RESET;
                  tree_d[TREE_SENSE_A]  = go_close;
                  tree_d[TREE_SOURCE_B] = go_close;
               end
            end
            default: begin
            end
         endcase
      end
      // the detector wins over any close in the same cycle
      // the detector passes two flops, so the relays open two clocks late
      // and a close that lands while the level is high is lost
      if (ovp_s) begin
         relay_d = 1'b0;
      end
      // bit 7 follows the relay command, not the settled contacts
      status_d = '0;
      status_d[STAT_RELAY_OPEN] = ~relay_d;
      status_d[STAT_NO_CABLE]   = cable_n_s;
   end

   // everything open out of reset
   // status resets to relays open and no cable seen
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_a_q      <= BANK_RESET;
         bank_b_q      <= BANK_RESET;
         tree_q        <= TREE_RESET;
         relay_close_q <= 1'b0;
         odd_q         <= 1'b0;
         path_ribbon_q <= 1'b0;
         status_q      <= STAT_RESET;
      end else begin
         bank_a_q      <= bank_a_d;
         bank_b_q      <= bank_b_d;
         tree_q        <= tree_d;
         relay_close_q <= relay_d;
         odd_q         <= odd_d;
         path_ribbon_q <= path_d;
         status_q      <= status_d;
      end
   end

endmodule
`default_nettype wire

// ===== dv/fet_mux_switch_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fet_mux_chk (
   input wire logic                                sys_clk,
   input wire logic                                rstn,
   input wire logic                                single_ended,
   input wire logic                                bp_valid,
   input wire logic [fet_mux_pkg::CMD_W-1:0]       bp_chan,
   input wire logic                                bp_close,
   input wire logic                                rib_strobe,
   input wire logic                                rib_cable_n,
   input wire logic                                overvoltage,
   input wire logic [fet_mux_pkg::BANK_CHANS-1:0]  bank_a_q,
   input wire logic [fet_mux_pkg::BANK_CHANS-1:0]  bank_b_q,
   input wire logic [fet_mux_pkg::TREE_PAIRS-1:0]  tree_q,
   input wire logic                                path_ribbon_q,
   input wire logic                                relay_close_q,
   input wire logic [fet_mux_pkg::STAT_W-1:0]      status_q
);
   import fet_mux_pkg::*;
   // ****************************************
   // helpers and assertions
   // ****************************************
   logic [2:0]  up_q;
   logic [2:0]  up_d;
   logic        rdy;
   logic [23:0] both;
   logic [3:0]  tree_exp;
   // edges since reset release, saturating, so synchronisers have settled
   always_comb up_d = rdy ? up_q : up_q + 3'h1;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) up_q <= 3'h0;
      else up_q <= up_d;
   end
   // both banks as one pair index, and tree pattern of a differential close
   assign rdy      = (up_q == 3'h7);
   assign both     = {bank_b_q, bank_a_q};
   assign tree_exp = (bp_chan == CH_SOURCE) ? 4'hc : (bp_chan == CH_SENSE) ? 4'h3 :
                     (bp_chan == CH_TWO_WIRE) ? 4'hf : 4'h9;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_diff; !single_ended && !$past(single_ended) && !$past(single_ended, 2); endsequence
   sequence s_se; single_ended && $past(single_ended) && $past(single_ended, 2); endsequence
   sequence s_ov_low; !$past(overvoltage) && !$past(overvoltage, 2) && !$past(overvoltage, 3); endsequence
   sequence s_quiet; !bp_valid && !overvoltage && !rib_strobe; endsequence
   property p_one; $onehot0(bank_a_q) && $onehot0(bank_b_q); endproperty
   a_one: assert property (p_one) else $error("two channels closed in one bank");
   property p_diff; (rdy && bp_valid && bp_chan <= DIFF_LAST_CHAN) ##0 s_diff
      |=> both[$past(bp_chan[4:0])] == $past(bp_close); endproperty
   a_diff: assert property (p_diff) else $error("differential channel not switched");
   property p_se; (rdy && bp_valid && bp_chan <= SE_LAST_CHAN) ##0 s_se
      |=> both[$past(bp_chan[5:1])] == $past(bp_close); endproperty
   a_se: assert property (p_se) else $error("single-ended pair not switched");
   property p_tree; (rdy && bp_valid && bp_close && bp_chan >= CH_SOURCE && bp_chan <= CH_FOUR_WIRE) ##0 s_diff
      |=> tree_q == $past(tree_exp); endproperty
   a_tree: assert property (p_tree) else $error("wrong tree pairs closed");
   property p_cls; (rdy && bp_valid && bp_chan == CH_RELAY && bp_close) ##0 s_ov_low
      |=> relay_close_q && !status_q[STAT_RELAY_OPEN]; endproperty
   a_cls: assert property (p_cls) else $error("relay close not applied");
   property p_hold; s_quiet[*6] ##0 relay_close_q |=> relay_close_q; endproperty
   a_hold: assert property (p_hold) else $error("relay opened by itself");
   property p_ovr; overvoltage[*4] |=> !relay_close_q && status_q[STAT_RELAY_OPEN]; endproperty
   a_ovr: assert property (p_ovr) else $error("overvoltage left relay closed");
   property p_cable; (rdy && $stable(rib_cable_n))[*3] |=> status_q[STAT_NO_CABLE] == $past(rib_cable_n); endproperty
   a_cable: assert property (p_cable) else $error("cable status wrong");
   property p_path; rdy && bp_valid |=> !path_ribbon_q; endproperty
   a_path: assert property (p_path) else $error("path not on backplane");
endmodule
bind fet_mux_switch_control fet_mux_chk i_fet_mux_chk (.sys_clk, .rstn, .single_ended, .bp_valid, .bp_chan,
   .bp_close, .rib_strobe, .rib_cable_n, .overvoltage, .bank_a_q, .bank_b_q, .tree_q, .path_ribbon_q,
   .relay_close_q, .status_q);
`default_nettype wire

// ===== dv/fet_mux_voltmeter.sv
`timescale 1ns/1ps
`default_nettype none
module fet_mux_voltmeter (
   input  wire logic                           sys_clk,
   input  wire logic                           attached,
   output logic                                rib_strobe,
   output logic [fet_mux_pkg::CMD_W-1:0]       rib_chan,
   output logic                                rib_close,
   output logic                                rib_cable_n
);
   import fet_mux_pkg::*;
   // plugged cable pulls the detect line low
   assign rib_cable_n = !attached;
   initial begin
      rib_strobe = 1'b0;
      rib_chan   = 7'h00;
      rib_close  = 1'b0;
   end
   // setup 3 clocks, strobe high 4 clocks, then lines released to inverse
   task automatic send(input logic [CMD_W-1:0] ch, input logic cl);
      rib_chan  = ch;
      rib_close = cl;
      repeat (3) @(posedge sys_clk);
      #1 rib_strobe = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 rib_strobe = 1'b0;
      @(posedge sys_clk);
      #1 rib_chan = ~ch;
      rib_close = ~cl;
   endtask
endmodule
`default_nettype wire

// ===== dv/fet_mux_switch_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fet_mux_switch_control_tb;
   import fet_mux_pkg::*;
   typedef struct {int due; logic [37:0] v;} note_t;
   logic                  sys_clk, rstn, single_ended, bp_valid, bp_close, overvoltage, attached;
   logic                  rib_strobe, rib_close, rib_cable_n, path_ribbon_q, relay_close_q;
   logic [CMD_W-1:0]      bp_chan, rib_chan;
   logic [BANK_CHANS-1:0] bank_a_q, bank_b_q;
   logic [TREE_PAIRS-1:0] tree_q;
   logic [STAT_W-1:0]     status_q;
   logic [23:0]           eab;
   logic [3:0]            et;
   logic                  er, ep, se, odd;
   logic [7:0]            lf;
   note_t                 q[$];
   int                    cyc = 0;
   int                    n_mismatch = 0;
   int                    tests_run = 0;
   // ****************************************
   // design, voltmeter model, clock
   // ****************************************
   fet_mux_switch_control i_fet_mux_switch_control (.sys_clk, .rstn, .single_ended, .bp_valid, .bp_chan, .bp_close,
      .rib_strobe, .rib_chan, .rib_close, .rib_cable_n, .overvoltage, .bank_a_q, .bank_b_q, .tree_q,
      .path_ribbon_q, .relay_close_q, .status_q);
   fet_mux_voltmeter i_fet_mux_voltmeter (.sys_clk, .attached, .rib_strobe, .rib_chan, .rib_close, .rib_cable_n);
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // expected effect of one command on the switch state
   task automatic upd(input logic [6:0] ch, input logic cl, input logic rib);
      int i;
      i  = se ? ch >> 1 : ch;
      ep = rib;
      if (ch == CH_RELAY) er = cl;
      else if (ch >= CH_SOURCE && ch <= CH_FOUR_WIRE && !(se && ch == CH_FOUR_WIRE)) begin
         if (!cl) et = 4'h0;
         else if (se) et = (ch == CH_SOURCE ? 4'h4 : ch == CH_SENSE ? 4'h1 : 4'h5) << odd;
         else et = ch == CH_SOURCE ? 4'hc : ch == CH_SENSE ? 4'h3 : ch == CH_TWO_WIRE ? 4'hf : 4'h9;
      end else if (ch <= (se ? SE_LAST_CHAN : DIFF_LAST_CHAN)) begin
         if (cl && i < 12) eab[11:0] = 12'h000;
         if (cl && i >= 12) eab[23:12] = 12'h000;
         eab[i] = cl;
         odd    = ch[0];
      end
   endtask
   // status bit 6 is forced high while reset holds, cable or not
   task automatic note();
      q.push_back('{cyc, {eab, et, ep, er, ~er, ~attached | ~rstn, 6'h00}});
   endtask
   task automatic bp(input logic [6:0] ch, input logic cl, input logic keep);
      bp_valid = 1'b1;
      bp_chan  = ch;
      bp_close = cl;
      tick(1);
      upd(ch, cl, 1'b0);
      note();
      if (!keep) bp_valid = 1'b0;
   endtask
   task automatic rib(input logic [6:0] ch, input logic cl);
      i_fet_mux_voltmeter.send(ch, cl);
      tick(2);
      upd(ch, cl, 1'b1);
      note();
   endtask
   task automatic cmp(input logic [37:0] got, input logic [37:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t: outputs %h expected %h", $time, got, exp);
      end
   endtask
   // compare the oldest note in the cycle its result is due
   always @(negedge sys_clk) begin
      if (q.size() != 0 && q[0].due == cyc) begin
         cmp({bank_b_q, bank_a_q, tree_q, path_ribbon_q, relay_close_q, status_q}, q[0].v);
         void'(q.pop_front());
      end
   end
   task automatic finish_test();
      if (q.size() != 0) n_mismatch++; // a note never compared counts as lost
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end
   // main sequence
   initial begin
      {rstn, single_ended, bp_valid, bp_chan, bp_close, overvoltage, attached} = '0;
      {eab, et, er, ep, se, odd} = '0;
      lf = 8'h18;
      tick(4);
      note();
      rstn = 1'b1;
      tick(7);
      for (int k = 0; k < 8; k++) begin
         lf = nxt(lf);
         bp(7'(lf % 24), lf[0] | k[0], k != 7);
      end
      tick(1);
      for (int c = CH_SOURCE; c <= CH_FOUR_WIRE; c++) bp(7'(c), 1'b1, 1'b1);
      bp(CH_SENSE, 1'b0, 1'b0);
      tick(1);
      bp(CH_RELAY, 1'b1, 1'b0);
      tick(10);
      note();
      overvoltage = 1'b1;
      tick(6);
      er = 1'b0;
      note();
      overvoltage = 1'b0;
      tick(4);
      bp(CH_RELAY, 1'b1, 1'b1);
      bp(CH_RELAY, 1'b0, 1'b0);
      attached = 1'b1;
      rib(7'h05, 1'b1);
      bp(7'h1e, 1'b1, 1'b0);
      single_ended = 1'b1;
      se = 1'b1;
      tick(4);
      bp(7'h0d, 1'b1, 1'b1);
      bp(CH_FOUR_WIRE, 1'b1, 1'b1);
      bp(CH_SOURCE, 1'b1, 1'b1);
      bp(7'h2e, 1'b1, 1'b1);
      bp(CH_SENSE, 1'b1, 1'b1);
      bp(CH_TWO_WIRE, 1'b1, 1'b1);
      bp(CH_RELAY, 1'b1, 1'b0);
      tick(1);
      rstn = 1'b0;
      {eab, et, er, ep} = '0;
      tick(1);
      note();
      rstn = 1'b1;
      tick(6);
      note();
      tick(1);
      finish_test();
   end
endmodule
`default_nettype wire
